// *** ctsc_pkg.sv ***
// Shared constants, types and helper functions for the compelled tone codec.
// Assumes one 10 MHz clock common to both ends of the trunk link.
package ctsc_pkg;
  localparam int NUM_CH = 2;
  localparam int FREQS = 6;
  localparam int ROUTES = 4;
  localparam int SIGNALS = 16;
  localparam int TBL_SIZE = ROUTES * 2 * SIGNALS;
  localparam int MAX_DIG_MFC = 15;
  localparam int MAX_DIG_FR = 10;

  // Tone plan, Hz: forward and backward sets, French variant sets
  localparam int FWD_LOW_HZ = 1380;
  localparam int FWD_HIGH_HZ = 1980;
  localparam int BWD_HIGH_HZ = 1140;
  localparam int BWD_LOW_HZ = 540;
  localparam int FR_LOW_HZ = 700;
  localparam int FR_HIGH_HZ = 1500;
  localparam int FR_CTRL_HZ = 1900;

  // Timing
  localparam int CLK_NS = 100;
  localparam int FRAME_NS = 125000;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  localparam int IGNORE_NS = 8000000;
  localparam int DET_FRAMES = (IGNORE_NS + FRAME_NS - 1) / FRAME_NS;

  typedef logic [3:0] digit_t;
  typedef logic [5:0] mask_t;
  typedef logic [3:0] func_t;
  typedef logic [3:0] lvl_t;
  typedef logic [7:0] pcm_t;
  typedef logic [14:0] lin_t;
  typedef logic [1:0] route_t;
  typedef logic [6:0] tidx_t;
  typedef logic [6:0] cnt_t;
  typedef logic [10:0] fcnt_t;
  typedef struct packed {
    mask_t mask;
    cnt_t cnt;
  } det_t;

  localparam fcnt_t FRAME_LAST = fcnt_t'(FRAME_CYC - 1);
  localparam cnt_t DET_LAST = cnt_t'(DET_FRAMES - 1);
  localparam mask_t CTRL_MASK = 6'h01;
  localparam pcm_t A_INV = 8'h55;
  localparam pcm_t MU_INV = 8'hff;
  localparam lin_t MU_BIAS = 15'h0084;
  // Weakest tone level still clears the receive threshold under either law
  localparam lin_t MIN_LIN = 15'h0008;

  // Digit n maps to the n-th pair (lo, hi) taken in order of rising hi
  function automatic mask_t pair_mask(digit_t d);
    int k;
    mask_t m;
    k = 0;
    m = '0;
    for (int hi = 1; hi < FREQS; hi++) begin
      for (int lo = 0; lo < hi; lo++) begin
        k++;
        if (k == int'(d)) begin
          m = mask_t'((1 << hi) | (1 << lo));
        end
      end
    end
    return m;
  endfunction : pair_mask

  // Zero when the mask is not exactly one legal pair
  function automatic digit_t decode(mask_t m, int max_dig);
    digit_t d;
    d = '0;
    for (int i = 1; i <= max_dig; i++) begin
      if (m != '0 && pair_mask(digit_t'(i)) == m) begin
        d = digit_t'(i);
      end
    end
    return d;
  endfunction : decode

  function automatic pcm_t law_inv(logic mu);
    return mu ? MU_INV : A_INV;
  endfunction : law_inv

  // Tone level code 0..15 sits in the segment and mantissa of the sample
  function automatic pcm_t compress(logic mu, logic on, lvl_t l);
    return (on ? {1'b0, l, 3'h7} : 8'h00) ^ law_inv(mu);
  endfunction : compress

  function automatic lin_t expand(logic mu, pcm_t b);
    pcm_t c;
    lin_t v;
    c = b ^ law_inv(mu);
    if (mu) begin
      v = (lin_t'({1'b1, c[3:0], 3'h4}) << c[6:4]) - MU_BIAS;
    end else if (c[6:4] == 3'h0) begin
      v = lin_t'({c[3:0], 1'b1});
    end else begin
      v = lin_t'({1'b1, c[3:0], 1'b1}) << (c[6:4] - 3'h1);
    end
    return v;
  endfunction : expand

  // Debounce: a changed candidate must persist for DET_FRAMES frames
  function automatic det_t det_next(mask_t cur, logic ok, det_t d);
    det_t n;
    mask_t cand;
    n = d;
    cand = ok ? cur : '0;
    if (cand == d.mask) begin
      n.cnt = '0;
    end else if (d.cnt == DET_LAST) begin
      n.mask = cand;
      n.cnt = '0;
    end else begin
      n.cnt = d.cnt + cnt_t'(1);
    end
    return n;
  endfunction : det_next

  function automatic tidx_t tbl_index(route_t r, logic l2, digit_t s);
    return {r, l2, s};
  endfunction : tbl_index
endpackage : ctsc_pkg

// *** ctsc_link_if.sv ***
// Trunk link between the two sender-receivers: one slot pair per channel.
// Assumes both ends share clk; frame marks each 8 kHz sample.
`timescale 1ns/1ps
interface ctsc_link_if;
  import ctsc_pkg::*;
  logic frame;
  mask_t [NUM_CH-1:0] fwd_mask;
  pcm_t [NUM_CH-1:0] fwd_pcm;
  mask_t [NUM_CH-1:0] bwd_mask;
  pcm_t [NUM_CH-1:0] bwd_pcm;
  modport orig (
    output frame,
    output fwd_mask,
    output fwd_pcm,
    input bwd_mask,
    input bwd_pcm
  );
  modport answ (
    input frame,
    input fwd_mask,
    input fwd_pcm,
    output bwd_mask,
    output bwd_pcm
  );
endinterface : ctsc_link_if

// *** ctsc_orig.sv ***
// Originating sender-receiver: sends forward pairs, hears backward replies.
// Assumes the answering end shares clk and reads the frame strobe driven here.
//
// How it works
// - Release frees the channel after signalling
// - Every forward pair is answered backward
// - Forward stays on until reply heard
// - Answerer holds reply until forward stops
// - New forward only once both gone
// - Forward digits 1-15 from six tones
// - Backward digits 1-15 from other six
// - Per-route table gives each signal's meaning
// - Level two only after level one
// - Group A at level one, B later
// - French forward digits 1-10, five tones
// - French reply is one control tone
// - A-law or mu-law chosen by setting
// - Two channels run independently
// - Each channel owns its slot pair
// - Received pairs decoded and reported
// - Host names pair, block sends it
// - Both tones switch in same frame
// - Detect and release under 32 ms
// - Tone level one of sixteen
`timescale 1ns/1ps
module ctsc_orig (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Settings
  input wire logic law_mu,
  input wire logic french,
  input wire ctsc_pkg::route_t [ctsc_pkg::NUM_CH-1:0] route_sel,
  // Send requests
  input wire logic [ctsc_pkg::NUM_CH-1:0] req_valid,
  output logic [ctsc_pkg::NUM_CH-1:0] req_ready,
  input wire ctsc_pkg::digit_t [ctsc_pkg::NUM_CH-1:0] req_digit,
  input wire logic [ctsc_pkg::NUM_CH-1:0] req_level2,
  input wire ctsc_pkg::lvl_t [ctsc_pkg::NUM_CH-1:0] req_tone_level,
  // Call control
  input wire logic [ctsc_pkg::NUM_CH-1:0] level1_done,
  input wire logic [ctsc_pkg::NUM_CH-1:0] release_call,
  output logic [ctsc_pkg::NUM_CH-1:0] busy,
  // Backward reports
  output logic [ctsc_pkg::NUM_CH-1:0] rpt_valid,
  output ctsc_pkg::digit_t [ctsc_pkg::NUM_CH-1:0] rpt_digit,
  output ctsc_pkg::func_t [ctsc_pkg::NUM_CH-1:0] rpt_func,
  output logic [ctsc_pkg::NUM_CH-1:0] rpt_group_b,
  output logic [ctsc_pkg::NUM_CH-1:0] rpt_gone,
  // Function table write
  input wire logic tbl_we,
  input wire ctsc_pkg::route_t tbl_route,
  input wire logic tbl_level2,
  input wire ctsc_pkg::digit_t tbl_sig,
  input wire ctsc_pkg::func_t tbl_func,
  // Trunk link
  ctsc_link_if.orig link
);
  import ctsc_pkg::*;

  typedef enum logic [1:0] {CH_FREE, CH_IDLE, CH_FWD, CH_WAIT_OFF} ctsc_ch_state_t;

  // Frame timing
  fcnt_t frame_cnt;
  fcnt_t next_frame_cnt;
  logic frame;
  logic next_frame;

  always_comb begin
    next_frame = 1'b0;
    if (frame_cnt == FRAME_LAST) begin
      next_frame_cnt = '0;
      next_frame = 1'b1;
    end else begin
      next_frame_cnt = frame_cnt + fcnt_t'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_cnt <= '0;
      frame <= 1'b0;
    end else if (ce) begin
      frame_cnt <= next_frame_cnt;
      frame <= next_frame;
    end
  end

  assign link.frame = frame & ce;

  // Route function table
  func_t tbl [TBL_SIZE];
  func_t next_tbl [TBL_SIZE];

  always_comb begin
    next_tbl = tbl;
    if (tbl_we) begin
      next_tbl[tbl_index(tbl_route, tbl_level2, tbl_sig)] = tbl_func;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tbl <= '{default: '0};
    end else if (ce) begin
      tbl <= next_tbl;
    end
  end

  // Channels
  ctsc_ch_state_t st [NUM_CH];
  ctsc_ch_state_t next_st [NUM_CH];
  digit_t [NUM_CH-1:0] dig;
  digit_t [NUM_CH-1:0] next_dig;
  lvl_t [NUM_CH-1:0] tlvl;
  lvl_t [NUM_CH-1:0] next_tlvl;
  logic [NUM_CH-1:0] lvl2;
  logic [NUM_CH-1:0] next_lvl2;
  logic [NUM_CH-1:0] l1done;
  logic [NUM_CH-1:0] next_l1done;
  det_t [NUM_CH-1:0] det;
  det_t [NUM_CH-1:0] next_det;
  mask_t [NUM_CH-1:0] tx_mask;
  mask_t [NUM_CH-1:0] next_tx_mask;
  pcm_t [NUM_CH-1:0] tx_pcm;
  pcm_t [NUM_CH-1:0] next_tx_pcm;
  logic [NUM_CH-1:0] next_rpt_valid;
  digit_t [NUM_CH-1:0] next_rpt_digit;
  func_t [NUM_CH-1:0] next_rpt_func;
  logic [NUM_CH-1:0] next_rpt_group_b;
  logic [NUM_CH-1:0] next_rpt_gone;

  always_comb begin
    det_t dn;
    logic onset;
    logic gone;
    logic rx_ok;
    logic rx_valid;
    logic legal;
    digit_t rd;
    dn = '0;
    onset = 1'b0;
    gone = 1'b0;
    rx_ok = 1'b0;
    rx_valid = 1'b0;
    legal = 1'b0;
    rd = '0;
    next_st = st;
    next_dig = dig;
    next_tlvl = tlvl;
    next_lvl2 = lvl2;
    next_l1done = l1done;
    next_det = det;
    next_tx_mask = tx_mask;
    next_tx_pcm = tx_pcm;
    next_rpt_valid = '0;
    next_rpt_digit = rpt_digit;
    next_rpt_func = rpt_func;
    next_rpt_group_b = rpt_group_b;
    next_rpt_gone = '0;
    req_ready = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      // Receive slot of this channel, expanded before detection
      rx_ok = expand(law_mu, link.bwd_pcm[c]) >= MIN_LIN;
      rx_valid = french ? (link.bwd_mask[c] == CTRL_MASK)
                        : (decode(link.bwd_mask[c], MAX_DIG_MFC) != '0);
      dn = det[c];
      if (frame) begin
        dn = det_next(link.bwd_mask[c], rx_ok && rx_valid, det[c]);
      end
      onset = (dn.mask != '0) && (dn.mask != det[c].mask);
      gone = (dn.mask == '0) && (det[c].mask != '0);
      next_det[c] = dn;
      rd = french ? digit_t'(0) : decode(dn.mask, MAX_DIG_MFC);
      if (onset) begin
        next_rpt_valid[c] = 1'b1;
        next_rpt_digit[c] = rd;
        next_rpt_func[c] = tbl[tbl_index(route_sel[c], lvl2[c], rd)];
        next_rpt_group_b[c] = lvl2[c];
      end
      next_rpt_gone[c] = gone;
      legal = (req_digit[c] != '0) &&
              (int'(req_digit[c]) <= (french ? MAX_DIG_FR : MAX_DIG_MFC));
      req_ready[c] = (st[c] == CH_FREE || st[c] == CH_IDLE) &&
                     det[c].mask == '0 && tx_mask[c] == '0 && legal &&
                     (!req_level2[c] || l1done[c]);
      unique case (st[c])
        CH_FREE, CH_IDLE: begin
          if (req_valid[c] && req_ready[c]) begin
            next_st[c] = CH_FWD;
            next_dig[c] = req_digit[c];
            next_lvl2[c] = req_level2[c];
            next_tlvl[c] = req_tone_level[c];
          end else if (st[c] == CH_IDLE && release_call[c] &&
                       det[c].mask == '0 && tx_mask[c] == '0) begin
            next_st[c] = CH_FREE;
            next_l1done[c] = 1'b0;
            next_lvl2[c] = 1'b0;
          end else if (st[c] == CH_IDLE && level1_done[c]) begin
            next_l1done[c] = 1'b1;
          end
        end
        CH_FWD: begin
          if (onset) begin
            next_st[c] = CH_WAIT_OFF;
          end
        end
        CH_WAIT_OFF: begin
          if (gone) begin
            next_st[c] = CH_IDLE;
          end
        end
      endcase
      // Both tones of the pair change on the same sample
      if (frame) begin
        next_tx_mask[c] = (st[c] == CH_FWD) ? pair_mask(dig[c]) : '0;
        next_tx_pcm[c] = compress(law_mu, st[c] == CH_FWD, tlvl[c]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{default: CH_FREE};
      dig <= '0;
      tlvl <= '0;
      lvl2 <= '0;
      l1done <= '0;
      det <= '0;
      tx_mask <= '0;
      tx_pcm <= {NUM_CH{A_INV}};
      rpt_valid <= '0;
      rpt_digit <= '0;
      rpt_func <= '0;
      rpt_group_b <= '0;
      rpt_gone <= '0;
    end else if (ce) begin
      st <= next_st;
      dig <= next_dig;
      tlvl <= next_tlvl;
      lvl2 <= next_lvl2;
      l1done <= next_l1done;
      det <= next_det;
      tx_mask <= next_tx_mask;
      tx_pcm <= next_tx_pcm;
      rpt_valid <= next_rpt_valid;
      rpt_digit <= next_rpt_digit;
      rpt_func <= next_rpt_func;
      rpt_group_b <= next_rpt_group_b;
      rpt_gone <= next_rpt_gone;
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      busy[c] = st[c] != CH_FREE;
    end
  end

  assign link.fwd_mask = tx_mask;
  assign link.fwd_pcm = tx_pcm;
endmodule : ctsc_orig

// *** ctsc_answ.sv ***
// Answering sender-receiver: hears forward pairs, returns compelled replies.
// Assumes the originating end drives the frame strobe on the shared clk.
`timescale 1ns/1ps
module ctsc_answ (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Settings
  input wire logic law_mu,
  input wire logic french,
  // Forward reports
  output logic [ctsc_pkg::NUM_CH-1:0] fwd_valid,
  output ctsc_pkg::digit_t [ctsc_pkg::NUM_CH-1:0] fwd_digit,
  output logic [ctsc_pkg::NUM_CH-1:0] fwd_gone,
  // Reply requests
  input wire logic [ctsc_pkg::NUM_CH-1:0] rep_valid,
  output logic [ctsc_pkg::NUM_CH-1:0] rep_ready,
  input wire ctsc_pkg::digit_t [ctsc_pkg::NUM_CH-1:0] rep_digit,
  input wire ctsc_pkg::lvl_t [ctsc_pkg::NUM_CH-1:0] rep_tone_level,
  // Trunk link
  ctsc_link_if.answ link
);
  import ctsc_pkg::*;

  typedef enum logic [1:0] {AN_IDLE, AN_GOT, AN_BWD} ctsc_an_state_t;

  ctsc_an_state_t st [NUM_CH];
  ctsc_an_state_t next_st [NUM_CH];
  mask_t [NUM_CH-1:0] bmask;
  mask_t [NUM_CH-1:0] next_bmask;
  lvl_t [NUM_CH-1:0] tlvl;
  lvl_t [NUM_CH-1:0] next_tlvl;
  det_t [NUM_CH-1:0] det;
  det_t [NUM_CH-1:0] next_det;
  mask_t [NUM_CH-1:0] tx_mask;
  mask_t [NUM_CH-1:0] next_tx_mask;
  pcm_t [NUM_CH-1:0] tx_pcm;
  pcm_t [NUM_CH-1:0] next_tx_pcm;
  logic [NUM_CH-1:0] next_fwd_valid;
  digit_t [NUM_CH-1:0] next_fwd_digit;
  logic [NUM_CH-1:0] next_fwd_gone;

  always_comb begin
    det_t dn;
    logic onset;
    logic gone;
    logic ok;
    dn = '0;
    onset = 1'b0;
    gone = 1'b0;
    ok = 1'b0;
    next_st = st;
    next_bmask = bmask;
    next_tlvl = tlvl;
    next_det = det;
    next_tx_mask = tx_mask;
    next_tx_pcm = tx_pcm;
    next_fwd_valid = '0;
    next_fwd_digit = fwd_digit;
    next_fwd_gone = '0;
    rep_ready = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      ok = expand(law_mu, link.fwd_pcm[c]) >= MIN_LIN &&
           decode(link.fwd_mask[c], french ? MAX_DIG_FR : MAX_DIG_MFC) != '0;
      dn = det[c];
      if (link.frame) begin
        dn = det_next(link.fwd_mask[c], ok, det[c]);
      end
      onset = (dn.mask != '0) && (dn.mask != det[c].mask);
      gone = (dn.mask == '0) && (det[c].mask != '0);
      next_det[c] = dn;
      if (onset) begin
        next_fwd_valid[c] = 1'b1;
        next_fwd_digit[c] = decode(dn.mask, MAX_DIG_MFC);
      end
      next_fwd_gone[c] = gone;
      rep_ready[c] = st[c] == AN_GOT && !gone && (french || rep_digit[c] != '0);
      unique case (st[c])
        AN_IDLE: begin
          if (onset) begin
            next_st[c] = AN_GOT;
          end
        end
        AN_GOT: begin
          if (gone) begin
            next_st[c] = AN_IDLE;
          end else if (rep_valid[c] && rep_ready[c]) begin
            next_st[c] = AN_BWD;
            next_bmask[c] = french ? CTRL_MASK : pair_mask(rep_digit[c]);
            next_tlvl[c] = rep_tone_level[c];
          end
        end
        AN_BWD: begin
          if (gone) begin
            next_st[c] = AN_IDLE;
          end
        end
      endcase
      if (link.frame) begin
        next_tx_mask[c] = (st[c] == AN_BWD) ? bmask[c] : '0;
        next_tx_pcm[c] = compress(law_mu, st[c] == AN_BWD, tlvl[c]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{default: AN_IDLE};
      bmask <= '0;
      tlvl <= '0;
      det <= '0;
      tx_mask <= '0;
      tx_pcm <= {NUM_CH{A_INV}};
      fwd_valid <= '0;
      fwd_digit <= '0;
      fwd_gone <= '0;
    end else if (ce) begin
      st <= next_st;
      bmask <= next_bmask;
      tlvl <= next_tlvl;
      det <= next_det;
      tx_mask <= next_tx_mask;
      tx_pcm <= next_tx_pcm;
      fwd_valid <= next_fwd_valid;
      fwd_digit <= next_fwd_digit;
      fwd_gone <= next_fwd_gone;
    end
  end

  assign link.bwd_mask = tx_mask;
  assign link.bwd_pcm = tx_pcm;
endmodule : ctsc_answ

// *** ctsc_link_properties.sv ***
// Concurrent checks on the trunk link joining the two codec ends.
// Assumes ce is held high, so a frame strobe comes every FRAME_CYC cycles.
`timescale 1ns/1ps
module ctsc_link_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  input wire logic frame,
  input wire ctsc_pkg::mask_t [ctsc_pkg::NUM_CH-1:0] fwd_mask,
  input wire ctsc_pkg::pcm_t [ctsc_pkg::NUM_CH-1:0] fwd_pcm,
  input wire ctsc_pkg::mask_t [ctsc_pkg::NUM_CH-1:0] bwd_mask,
  input wire ctsc_pkg::pcm_t [ctsc_pkg::NUM_CH-1:0] bwd_pcm
);
  import ctsc_pkg::*;
  int gap;
  int next_gap;
  logic primed;
  logic next_primed;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Cycles since the last strobe; primed once the first strobe is seen
  always_comb begin
    next_gap = frame ? 0 : gap + 1;
    next_primed = primed | frame;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap <= 0;
      primed <= 1'b0;
    end else begin
      gap <= next_gap;
      primed <= next_primed;
    end
  end

  frame_period_a: assert property (frame && primed |-> gap == FRAME_CYC - 1)
    else $error("frame strobe spacing wrong");
  frame_pulse_a: assert property (frame |=> !frame)
    else $error("frame strobe longer than one cycle");

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    fwd_pair_a: assert property (
      $countones(fwd_mask[c]) == 0 || $countones(fwd_mask[c]) == 2)
      else $error("forward slot holds no clean tone pair");
    fwd_on_frame_a: assert property ($changed(fwd_mask[c]) |-> frame || $past(frame))
      else $error("forward tones switched off a frame");
    bwd_on_frame_a: assert property ($changed(bwd_mask[c]) |-> frame || $past(frame))
      else $error("backward tones switched off a frame");
    fwd_held_a: assert property ($past(fwd_mask[c]) != '0 && fwd_mask[c] == '0
      |-> bwd_mask[c] != '0)
      else $error("forward dropped without a reply");
    bwd_held_a: assert property ($past(bwd_mask[c]) != '0 && bwd_mask[c] == '0
      |-> fwd_mask[c] == '0)
      else $error("reply dropped while forward still on");
    bwd_compelled_a: assert property ($past(bwd_mask[c]) == '0 && bwd_mask[c] != '0
      |-> fwd_mask[c] != '0)
      else $error("reply sent with no forward signal");
    fwd_start_a: assert property ($past(fwd_mask[c]) == '0 && fwd_mask[c] != '0
      |-> bwd_mask[c] == '0)
      else $error("forward started while reply still on");
    idle_code_a: assert property (fwd_mask[c] == '0
      |-> fwd_pcm[c] == A_INV || fwd_pcm[c] == MU_INV)
      else $error("silent forward slot carries a tone code");
    bwd_idle_a: assert property (bwd_mask[c] == '0
      |-> bwd_pcm[c] == A_INV || bwd_pcm[c] == MU_INV)
      else $error("silent backward slot carries a tone code");
    cover property ($past(fwd_mask[c]) == '0 && fwd_mask[c] != '0);
    cover property ($past(bwd_mask[c]) == '0 && bwd_mask[c] != '0);
    cover property ($past(fwd_mask[c]) != '0 && fwd_mask[c] == '0);
  end
endmodule : ctsc_link_properties

// *** tb_compelled_tone_signaling_codec.sv ***
// Self-checking bench: both codec ends face each other over the link.
// Assumes one 10 MHz clock; each detection takes a full debounce time.
`timescale 1ns/1ps
module tb_compelled_tone_signaling_codec;
  import ctsc_pkg::*;
  localparam int LIM = 90000;
  typedef struct packed {
    logic fr;
    digit_t dig;
    logic l2;
    logic ok;
  } ctsc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic law_mu = 1'b0;
  logic french = 1'b0;
  route_t [NUM_CH-1:0] route_sel = '0;
  logic [NUM_CH-1:0] req_valid = '0, req_level2 = '0, level1_done = '0;
  logic [NUM_CH-1:0] release_call = '0, rep_valid = '0;
  digit_t [NUM_CH-1:0] req_digit = '0, rep_digit = '0;
  lvl_t [NUM_CH-1:0] req_tone_level = '0, rep_tone_level = '0;
  logic tbl_we = 1'b0;
  logic tbl_level2 = 1'b0;
  route_t tbl_route = '0;
  digit_t tbl_sig = '0;
  func_t tbl_func = '0;
  logic [NUM_CH-1:0] req_ready, busy, rpt_valid, rpt_group_b, rpt_gone;
  logic [NUM_CH-1:0] fwd_valid, fwd_gone, rep_ready;
  digit_t [NUM_CH-1:0] rpt_digit, fwd_digit;
  func_t [NUM_CH-1:0] rpt_func;
  digit_t cap_d [NUM_CH];
  func_t cap_f [NUM_CH];
  logic cap_g [NUM_CH];
  int err_count = 0;
  int samples_checked = 0;
  ctsc_row_t rows [6] = '{'{1'b0, 4'h0, 1'b0, 1'b0}, '{1'b0, 4'hf, 1'b0, 1'b1},
    '{1'b0, 4'h1, 1'b0, 1'b1}, '{1'b1, 4'ha, 1'b0, 1'b1}, '{1'b1, 4'hb, 1'b0, 1'b0},
    '{1'b0, 4'h5, 1'b1, 1'b0}};

  always #50 clk = ~clk;

  ctsc_link_if i_ctsc_link_if ();
  ctsc_orig i_ctsc_orig (.clk(clk), .rst_n(rst_n), .ce(1'b1), .law_mu(law_mu),
    .french(french), .route_sel(route_sel), .req_valid(req_valid), .req_ready(req_ready),
    .req_digit(req_digit), .req_level2(req_level2), .req_tone_level(req_tone_level),
    .level1_done(level1_done), .release_call(release_call), .busy(busy),
    .rpt_valid(rpt_valid), .rpt_digit(rpt_digit), .rpt_func(rpt_func),
    .rpt_group_b(rpt_group_b), .rpt_gone(rpt_gone), .tbl_we(tbl_we), .tbl_route(tbl_route),
    .tbl_level2(tbl_level2), .tbl_sig(tbl_sig), .tbl_func(tbl_func), .link(i_ctsc_link_if));
  ctsc_answ i_ctsc_answ (.clk(clk), .rst_n(rst_n), .ce(1'b1), .law_mu(law_mu),
    .french(french), .fwd_valid(fwd_valid), .fwd_digit(fwd_digit), .fwd_gone(fwd_gone),
    .rep_valid(rep_valid), .rep_ready(rep_ready), .rep_digit(rep_digit),
    .rep_tone_level(rep_tone_level), .link(i_ctsc_link_if));
  ctsc_link_properties i_ctsc_link_properties (.clk(clk), .rst_n(rst_n),
    .frame(i_ctsc_link_if.frame), .fwd_mask(i_ctsc_link_if.fwd_mask),
    .fwd_pcm(i_ctsc_link_if.fwd_pcm), .bwd_mask(i_ctsc_link_if.bwd_mask),
    .bwd_pcm(i_ctsc_link_if.bwd_pcm));

  task automatic test_done();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Event per channel: 0 fwd onset, 1 reply onset, 2 fwd gone, 3 reply gone, 4/5 tones on
  function automatic logic [NUM_CH-1:0] ev_vec(input int ev);
    case (ev)
      0: return fwd_valid;
      1: return rpt_valid;
      2: return fwd_gone;
      3: return rpt_gone;
      4: return {i_ctsc_link_if.fwd_mask[1] != '0, i_ctsc_link_if.fwd_mask[0] != '0};
      default: return {i_ctsc_link_if.bwd_mask[1] != '0, i_ctsc_link_if.bwd_mask[0] != '0};
    endcase
  endfunction : ev_vec

  // Waits until the event has shown on every channel, capturing the reports
  task automatic wait_all(input int ev);
    logic [NUM_CH-1:0] seen;
    logic [NUM_CH-1:0] v;
    int n;
    seen = '0;
    n = 0;
    while (seen != '1 && n < LIM) begin
      @(posedge clk);
      #1;
      n++;
      v = ev_vec(ev);
      for (int c = 0; c < NUM_CH; c++) begin
        if (v[c] === 1'b1 && !seen[c]) begin
          seen[c] = 1'b1;
          cap_d[c] = (ev == 0) ? fwd_digit[c] : rpt_digit[c];
          cap_f[c] = rpt_func[c];
          cap_g[c] = rpt_group_b[c];
        end
      end
    end
    if (seen != '1) begin
      err_count++;
      test_done();
    end
  endtask : wait_all

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(8'(busy), 8'h00);
    chk(i_ctsc_link_if.fwd_pcm[0], 8'h55);
    @(posedge clk);
    tbl_we <= 1'b1;
    tbl_sig <= 4'h1;
    tbl_func <= 4'h6;
    @(posedge clk);
    tbl_route <= 2'h1;
    tbl_sig <= 4'hf;
    tbl_func <= 4'h9;
    @(posedge clk);
    tbl_route <= 2'h0;
    tbl_func <= 4'h3;
    @(posedge clk);
    tbl_we <= 1'b0;
    foreach (rows[i]) begin
      french <= rows[i].fr;
      req_digit <= {NUM_CH{rows[i].dig}};
      req_level2 <= {NUM_CH{rows[i].l2}};
      @(negedge clk);
      chk(8'(req_ready), 8'({NUM_CH{rows[i].ok}}));
      @(posedge clk);
    end
    // Both channels signal at once, on different routes and levels
    french <= 1'b0;
    law_mu <= 1'b1;
    req_level2 <= '0;
    route_sel <= {2'h1, 2'h0};
    req_digit <= {4'h1, 4'hf};
    req_tone_level <= {4'h0, 4'h9};
    req_valid <= '1;
    @(negedge clk);
    chk(8'(req_ready), 8'h03);
    @(posedge clk);
    req_valid <= '0;
    wait_all(4);
    chk(8'(i_ctsc_link_if.fwd_mask[0]), 8'h30);
    chk(8'(i_ctsc_link_if.fwd_mask[1]), 8'h03);
    chk(i_ctsc_link_if.fwd_pcm[0], 8'h4f ^ 8'hff);
    chk(i_ctsc_link_if.fwd_pcm[1], 8'h07 ^ 8'hff);
    chk(8'(busy), 8'h03);
    wait_all(0);
    chk(8'(cap_d[0]), 8'h0f);
    chk(8'(cap_d[1]), 8'h01);
    @(posedge clk);
    rep_digit <= {4'hf, 4'h1};
    rep_tone_level <= {4'h3, 4'h3};
    rep_valid <= '1;
    @(negedge clk);
    chk(8'(rep_ready), 8'h03);
    @(posedge clk);
    rep_valid <= '0;
    wait_all(5);
    chk(8'(i_ctsc_link_if.bwd_mask[0]), 8'h03);
    chk(8'(i_ctsc_link_if.bwd_mask[1]), 8'h30);
    wait_all(1);
    chk({cap_d[1], cap_d[0]}, 8'hf1);
    chk({cap_f[1], cap_f[0]}, 8'h96);
    chk(8'({cap_g[1], cap_g[0]}), 8'h00);
    wait_all(2);
    chk(8'(i_ctsc_link_if.fwd_mask[0] | i_ctsc_link_if.fwd_mask[1]), 8'h00);
    wait_all(3);
    chk(8'(i_ctsc_link_if.bwd_mask[0] | i_ctsc_link_if.bwd_mask[1]), 8'h00);
    @(posedge clk);
    req_level2 <= '1;
    req_digit <= {4'h5, 4'h5};
    @(negedge clk);
    chk(8'(req_ready), 8'h00);
    @(posedge clk);
    level1_done <= '1;
    @(posedge clk);
    level1_done <= '0;
    @(negedge clk);
    chk(8'(req_ready), 8'h03);
    @(posedge clk);
    release_call <= '1;
    @(posedge clk);
    release_call <= '0;
    @(negedge clk);
    chk(8'(busy), 8'h00);
    // Reset lands while a fresh request waits for its frame
    @(posedge clk);
    req_level2 <= '0;
    req_valid <= '1;
    @(posedge clk);
    req_valid <= '0;
    @(negedge clk);
    chk(8'(busy), 8'h03);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (FRAME_CYC + 10) @(posedge clk);
    @(negedge clk);
    chk(8'(busy), 8'h00);
    chk(8'(i_ctsc_link_if.fwd_mask[0] | i_ctsc_link_if.fwd_mask[1]), 8'h00);
    test_done();
  end
endmodule : tb_compelled_tone_signaling_codec
